/* File: tb/stp_exec_chk.sv */
// assertion checker for the status transfer unit ports
`timescale 1ns/100ps
module stp_exec_chk
   import stp_pkg::*;
(
   // clock and reset
   input logic clock,
   input logic sys_rst,
   // issue side
   input logic issueValid,
   input logic [31:0] issueInstr,
   input logic [31:0] issueAddr,
   input logic [31:0] aluResult,
   // results
   input logic done,
   input logic condPassed,
   input stp_gpr_wr_t gprWrite,
   input stp_pc_wr_t pcWrite,
   input logic [31:0] pcOperand,
   input stp_cycles_t cycles,
   input logic [31:0] currentStatus,
   // register port
   input logic [3:0] regAddr,
   input logic [31:0] regWdata,
   input logic regWrite
);
   logic ctrlEn_r, ctrlEn_nxt, accLive, tstOp, regSh, dpS;
   // private copy of the enable bit, the control register is not visible here
   always_comb begin
      ctrlEn_nxt = ctrlEn_r;
      if (regWrite && regAddr == STP_REG_CTRL) begin
         ctrlEn_nxt = regWdata[STP_CTRL_EN_BIT];
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrlEn_r <= 1'b1;
      end else begin
         ctrlEn_r <= ctrlEn_nxt;
      end
   end
   assign accLive = issueValid && ctrlEn_r && !sys_rst;
   assign tstOp = issueValid && issueInstr[27:26] == STP_CLASS_DP
                  && issueInstr[24:23] == STP_XFER_MID && issueInstr[STP_S_BIT];
   assign regSh = !issueInstr[STP_IMM_BIT] && issueInstr[STP_RSHIFT_BIT];
   assign dpS = issueInstr[27:26] == STP_CLASS_DP && issueInstr[STP_S_BIT]
                && !(regSh && issueInstr[STP_MUL_BIT]);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_done;
      1'b1 |-> done == $past(accLive);
   endproperty
   a_done: assert property (p_done) else $error("done timing");
   property p_refuse;
      done && !condPassed |-> !gprWrite.en && !pcWrite.en && $stable(currentStatus);
   endproperty
   a_refuse: assert property (p_refuse) else $error("failed cond had effect");
   property p_test;
      tstOp |=> !gprWrite.en;
   endproperty
   a_test: assert property (p_test) else $error("test op wrote reg");
   property p_pcCyc;
      done && pcWrite.en |-> cycles.s == STP_CYC_TWO && cycles.n == STP_CYC_ONE;
   endproperty
   a_pcCyc: assert property (p_pcCyc) else $error("pc cycles");
   property p_plainCyc;
      done && !pcWrite.en |-> cycles.s == STP_CYC_ONE && cycles.n == STP_CYC_ZERO;
   endproperty
   a_plainCyc: assert property (p_plainCyc) else $error("plain cycles");
   property p_pcData;
      pcWrite.en |-> pcWrite.data == $past(aluResult);
   endproperty
   a_pcData: assert property (p_pcData) else $error("pc value");
   property p_ahead8;
      accLive && dpS && !regSh |=> pcOperand == $past(issueAddr) + STP_PC_AHEAD_IMM;
   endproperty
   a_ahead8: assert property (p_ahead8) else $error("pc op not +8");
   property p_ahead12;
      accLive && dpS && regSh |=> pcOperand == $past(issueAddr) + STP_PC_AHEAD_REG;
   endproperty
   a_ahead12: assert property (p_ahead12) else $error("pc op not +12");
   property p_user;
      currentStatus[4:0] == STP_MODE_USR |=> $stable(currentStatus[27:0]);
   endproperty
   a_user: assert property (p_user) else $error("user ctrl change");
   property p_resv;
      (currentStatus & ~STP_DEFINED_MASK) == 32'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
endmodule : stp_exec_chk

/* File: tb/stp_exec_tb.sv */
// self-checking bench for the status transfer unit
`timescale 1ns/100ps
module stp_exec_tb
   import stp_pkg::*;
();
   typedef struct packed {
      logic cp;
      stp_gpr_wr_t g;
      stp_pc_wr_t p;
      stp_cycles_t c;
      logic [31:0] s;
   } stp_note_t;
   logic clock, sys_rst, req, regWrite, regRead, issueValid, done, condPassed, en, rdPend;
   logic [31:0] reqInstr, reqAddr, reqSrc, reqAlu, issueInstr, issueAddr, srcRegVal;
   logic [31:0] aluResult, regWdata, regRdata, pcOperand, currentStatus, csw;
   logic [3:0] reqFlags, aluFlags, regAddr;
   stp_gpr_wr_t gprWrite;
   stp_pc_wr_t pcWrite;
   stp_cycles_t cycles, lastCyc;
   stp_note_t got;
   logic [31:0] sv [logic [4:0]];
   stp_note_t nq[$];
   logic [31:0] rq[$];
   int failures, cmp_count;
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   stp_instr_src stp_instr_src_inst (.*);
   stp_exec stp_exec_inst (.*);
   task automatic chkn(input stp_note_t g, input stp_note_t e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chkn
   task automatic chkw(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chkw
   task automatic results();
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   task automatic rst();
      req <= 1'b0;
      regRead <= 1'b0;
      regWrite <= 1'b0;
      regAddr <= 4'h0;
      regWdata <= 32'h0;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b1;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      csw = STP_CSW_RESET;
      sv[STP_MODE_SVC] = STP_SSW_RESET;
      sv[STP_MODE_FIQ] = STP_SSW_RESET;
      en = 1'b1;
   endtask : rst
   // reference behaviour covers only the forms this bench issues
   task automatic iss(input logic [31:0] ins, input logic [31:0] src, input logic [3:0] fl);
      stp_note_t n;
      logic [63:0] t;
      logic [31:0] w, alu;
      logic [4:0] m;
      logic fo;
      alu = $urandom;
      regRead <= 1'b0;
      regWrite <= 1'b0;
      req <= 1'b1;
      reqInstr <= ins;
      reqAddr <= $urandom & 32'hfffffffc;
      reqSrc <= src;
      reqAlu <= alu;
      reqFlags <= fl;
      m = csw[4:0];
      n = '0;
      n.cp = ins[31:28] == 4'he || ins[31:28] == {3'h0, ~csw[30]};
      n.c.s = STP_CYC_ONE;
      if (n.cp && ins[24:23] == 2'b10 && !ins[20]) begin
         if (!ins[21]) begin
            n.g = {1'b1, ins[15:12], ins[22] ? sv[m] : csw};
         end else begin
            t = {2{24'h0, ins[7:0]}} >> {ins[11:8], 1'b0};
            w = ins[25] ? t[31:0] : src;
            fo = ins[25] || !ins[12] || m == STP_MODE_USR;
            w = fo ? {w[31:28], ins[22] ? sv[m][27:0] : csw[27:0]} : w & STP_DEFINED_MASK;
            if (ins[22]) sv[m] = w; else csw = w;
         end
      end else if (n.cp && ins[15:12] == STP_PC_IDX && ins[24:21] == STP_OPC_TEQ) begin
         if (m != STP_MODE_USR) csw = sv[m] & STP_DEFINED_MASK;
      end else if (n.cp && ins[15:12] == STP_PC_IDX) begin
         n.p = {1'b1, alu};
         n.c = {STP_CYC_TWO, STP_CYC_ONE, 1'b0, !ins[25] && ins[4]};
         csw = sv[m] & STP_DEFINED_MASK;
      end else if (n.cp) begin
         n.c.i = {1'b0, !ins[25] && ins[4]};
         csw[31:28] = fl;
      end
      n.s = csw;
      if (en) begin
         nq.push_back(n);
         lastCyc = n.c;
      end
      @(posedge clock);
   endtask : iss
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      req <= 1'b0;
      regRead <= 1'b0;
      regWrite <= 1'b0;
      repeat (3) @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      rq.push_back(e);
      @(posedge clock);
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      req <= 1'b0;
      regRead <= 1'b0;
      repeat (3) @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
   endtask : wr
   always @(posedge clock) begin
      if (sys_rst === 1'b0) begin
         if (rdPend) chkw(regRdata, rq.pop_front());
         rdPend = regRead === 1'b1;
         if (done !== 1'b0) begin
            got = {condPassed, gprWrite.en === 1'b1 ? gprWrite : {gprWrite.en, 36'h0},
                   pcWrite.en === 1'b1 ? pcWrite : {pcWrite.en, 32'h0}, cycles, currentStatus};
            if (nq.size() == 0) chkn(got, '0);
            else chkn(got, nq.pop_front());
         end
      end
   end
   initial begin
      repeat (4000) @(posedge clock);
      failures++;
      results();
   end
   initial begin
      failures = 0;
      cmp_count = 0;
      rdPend = 1'b0;
      void'($urandom(32'h48bd));
      rst();
      rd(STP_REG_CSW, STP_CSW_RESET);
      rd(STP_REG_CTRL, STP_CTRL_RESET);
      rd(4'h2, 32'h0);
      iss(32'he10f3000, 32'h0, 4'h0);
      iss(32'he169f002, 32'h500000d3, 4'h0);
      iss(32'he14f4000, 32'h0, 4'h0);
      iss(32'he1b0f00e, 32'h0, 4'h0);
      iss(32'he1b0f21e, 32'h0, 4'h0);
      iss(32'h1129f002, 32'h00000013, 4'h0);
      iss(32'h0129e002, $urandom, 4'h0);
      for (int k = 0; k < 8; k++) begin
         iss({4'he, 2'b00, ~k[2], 2'b10, k[1:0], 1'b1, 8'h10, 7'h0, k[2], 4'h2},
             32'h0, 4'($urandom));
         iss({20'he329e, 12'($urandom)}, 32'h0, 4'h0);
         iss(32'he129e002, $urandom, 4'h0);
         iss(32'he10f1000, 32'h0, 4'h0);
      end
      iss(32'he169f002, 32'h300000d3, 4'h0);
      iss(32'he130f000, 32'h0, 4'h0);
      rd(STP_REG_SSW, 32'h300000d3);
      rd(STP_REG_CYC, {26'h0, lastCyc});
      wr(STP_REG_CSW, 32'h0);
      rd(STP_REG_CSW, csw);
      wr(STP_REG_CTRL, 32'h0);
      en = 1'b0;
      iss(32'he10f2000, 32'h0, 4'h0);
      wr(STP_REG_CTRL, 32'h1);
      en = 1'b1;
      rd(STP_REG_CTRL, 32'h1);
      iss(32'he129f002, 32'h000000d1, 4'h0);
      iss(32'he169f002, 32'h900000d3, 4'h0);
      iss(32'he14f5000, 32'h0, 4'h0);
      iss(32'he129f002, 32'h000000d3, 4'h0);
      iss(32'he14f6000, 32'h0, 4'h0);
      // user mode: no saved word access and no pc restore form
      iss(32'he129f002, 32'h000000d0, 4'h0);
      iss(32'he129f002, 32'hf00000d3, 4'h0);
      iss(32'he130f000, 32'h0, 4'h0);
      iss(32'he10f7000, 32'h0, 4'h0);
      rd(STP_REG_CSW, csw);
      rst();
      rd(STP_REG_CSW, STP_CSW_RESET);
      rd(STP_REG_CTRL, STP_CTRL_RESET);
      regRead <= 1'b0;
      repeat (2) @(posedge clock);
      results();
   end
endmodule : stp_exec_tb
bind stp_exec stp_exec_chk stp_exec_chk_inst (.*);

/* File: tb/stp_instr_src.sv */
// instruction stream source standing in for program memory
`timescale 1ns/100ps
module stp_instr_src
   import stp_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // requests from the bench
   input wire logic req,
   input wire logic [31:0] reqInstr,
   input wire logic [31:0] reqAddr,
   input wire logic [31:0] reqSrc,
   input wire logic [31:0] reqAlu,
   input wire logic [3:0] reqFlags,
   // issue side
   output logic issueValid,
   output logic [31:0] issueInstr,
   output logic [31:0] issueAddr,
   output logic [31:0] srcRegVal,
   output logic [31:0] aluResult,
   output logic [3:0] aluFlags
);
   logic xfer;
   logic pcNamed;
   assign xfer = reqInstr[27:26] == STP_CLASS_DP && reqInstr[24:23] == STP_XFER_MID
                 && !reqInstr[20];
   // a transfer naming the pc is never fetched
   assign pcNamed = xfer && (reqInstr[21] ? (!reqInstr[25] && reqInstr[3:0] == STP_PC_IDX)
                                          : reqInstr[15:12] == STP_PC_IDX);
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         issueValid <= 1'b0;
         issueInstr <= 32'h0;
         issueAddr <= 32'h0;
         srcRegVal <= 32'h0;
         aluResult <= 32'h0;
         aluFlags <= 4'h0;
      end else begin
         issueValid <= req && !pcNamed;
         // idle lines flip so a stale word never passes for a live one
         issueInstr <= req ? reqInstr : ~issueInstr;
         issueAddr <= req ? reqAddr : ~issueAddr;
         srcRegVal <= req ? {reqSrc[31:6], 1'b0, reqSrc[4:0]} : ~srcRegVal;
         aluResult <= req ? reqAlu : ~aluResult;
         aluFlags <= req ? reqFlags : ~aluFlags;
      end
   end
endmodule : stp_instr_src

/* File: verilog/stp_exec.sv */
// execution of status transfers, compare/test ops and program counter writeback
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps

//
// Contract
// RULE1: flagged pc destination loads pc and restores current word from saved.
// RULE2: software avoids the pc restore form in user mode.
// RULE3: pc operand with immediate shift reads address plus 8.
// RULE4: pc operand with register shift reads address plus 12.
// RULE5: test and compare ops update flags only, never a destination register.
// RULE6: legacy restore test copies saved word if privileged, else nothing.
// RULE7: cycles 1S, 1S+1I, 2S+1N, 2S+1N+1I by shift kind and pc write.
// RULE8: transfers decode as flagless test opcodes with fixed fields.
// RULE9: transfers act only when their condition passes.
// RULE10: status read copies current or saved word to a register.
// RULE11: status write loads current or saved word, mode protected.
// RULE12: flag form writes the top four source bits into the flags only.
// RULE13: user mode may change only flags; privileged modes write the whole word.
// RULE14: software never alters the state bit by a status write.
// RULE15: saved word reached is the bank of the executing mode.
// RULE16: software never names the pc in a status transfer.
// RULE17: software never reaches a saved word in user mode.
// RULE18: twelve defined status bits; all others reserved.
// RULE19: bit 22 selects current word at zero, saved word at one.
// RULE20: immediate flag form rotates the 8-bit value right by twice rotate field.
module stp_exec
   import stp_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // instruction issue
   input wire logic issueValid,
   input wire logic [31:0] issueInstr,
   input wire logic [31:0] issueAddr,
   input wire logic [31:0] srcRegVal,
   // neighbouring alu result
   input wire logic [31:0] aluResult,
   input wire logic [3:0] aluFlags,
   // execution results
   output logic done,
   output logic condPassed,
   output stp_gpr_wr_t gprWrite,
   output stp_pc_wr_t pcWrite,
   output logic [31:0] pcOperand,
   output stp_cycles_t cycles,
   output logic [31:0] currentStatus,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic cond_eval(input logic [3:0] c, input logic [3:0] f);
      logic n, z, cy, v, r;
      n = f[3];
      z = f[2];
      cy = f[1];
      v = f[0];
      case (stp_cond_t'(c))
         STP_EQ: r = z;
         STP_NE: r = !z;
         STP_CS: r = cy;
         STP_CC: r = !cy;
         STP_MI: r = n;
         STP_PL: r = !n;
         STP_VS: r = v;
         STP_VC: r = !v;
         STP_HI: r = cy && !z;
         STP_LS: r = !cy || z;
         STP_GE: r = (n == v);
         STP_LT: r = (n != v);
         STP_GT: r = !z && (n == v);
         STP_LE: r = z || (n != v);
         STP_AL: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : cond_eval

   function automatic logic [31:0] rot_imm(input logic [3:0] rot, input logic [7:0] imm);
      logic [63:0] twice;
      logic [4:0] amt;
      twice = {24'h000000, imm, 24'h000000, imm};
      amt = {rot, 1'b0};
      twice = twice >> amt;
      return twice[31:0];
   endfunction : rot_imm

   // ****************************************
   // state
   // ****************************************
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [31:0] csw_r, csw_nxt;
   logic done_r, done_nxt;
   logic pass_r, pass_nxt;
   stp_gpr_wr_t gpr_r, gpr_nxt;
   stp_pc_wr_t pc_r, pc_nxt;
   logic [31:0] pcop_r, pcop_nxt;
   stp_cycles_t cyc_r, cyc_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // ****************************************
   // decode
   // ****************************************
   logic [3:0] opc;
   logic sBit, immForm, regShift, rdIsPc, testOp, isRead, isWrite, isDp;
   logic isMul, userMode, hasBank, takeIt, flagOnly, toSaved;
   logic [4:0] mode;
   logic [2:0] bankIdx;
   logic [31:0] bankRd, sswCur, xferSrc, restoreVal;
   logic bankWe;
   logic [31:0] bankWd;

   assign opc = issueInstr[STP_OPC_HI:STP_OPC_LO];
   assign sBit = issueInstr[STP_S_BIT];
   assign immForm = issueInstr[STP_IMM_BIT];
   assign regShift = !immForm && issueInstr[STP_RSHIFT_BIT];
   assign isMul = !immForm && issueInstr[STP_MUL_BIT] && issueInstr[STP_RSHIFT_BIT];
   assign rdIsPc = (issueInstr[STP_RD_HI:STP_RD_LO] == STP_PC_IDX);
   assign testOp = (opc == STP_OPC_TST) || (opc == STP_OPC_TEQ)
                   || (opc == STP_OPC_CMP) || (opc == STP_OPC_CMN);
   // both transfer forms sit in the test opcodes with the flag bit clear
   assign isRead = (issueInstr[27:23] == STP_XFER_TOP) && !sBit
                   && (issueInstr[21:16] == STP_READ_FIXED)
                   && (issueInstr[11:0] == STP_READ_LOW); // RULE8
   assign isWrite = (issueInstr[STP_CLASS_HI:STP_CLASS_LO] == STP_CLASS_DP)
                    && (issueInstr[24:23] == STP_XFER_MID) && !sBit
                    && (issueInstr[21:13] == STP_WRITE_FIXED); // RULE8
   assign isDp = (issueInstr[STP_CLASS_HI:STP_CLASS_LO] == STP_CLASS_DP)
                 && !isMul && !(testOp && !sBit);
   assign toSaved = issueInstr[STP_SEL_BIT]; // RULE19
   assign flagOnly = immForm || !issueInstr[STP_WHOLE_BIT];

   assign mode = csw_r[STP_MODE_HI:STP_MODE_LO];
   assign userMode = (mode == STP_MODE_USR);

   // bank follows the mode in force when the instruction executes
   always_comb begin
      hasBank = 1'b1;
      case (mode)
         STP_MODE_FIQ: bankIdx = STP_BANK_FIQ; // RULE15
         STP_MODE_IRQ: bankIdx = STP_BANK_IRQ;
         STP_MODE_SVC: bankIdx = STP_BANK_SVC;
         STP_MODE_ABT: bankIdx = STP_BANK_ABT;
         STP_MODE_UND: bankIdx = STP_BANK_UND;
         default: begin
            bankIdx = STP_BANK_FIQ;
            hasBank = 1'b0;
         end
      endcase
   end

   // user and system modes have no saved word: it reads as zero
   assign sswCur = hasBank ? bankRd : STP_SSW_RESET; // RULE17
   assign restoreVal = sswCur & STP_DEFINED_MASK; // RULE18
   assign xferSrc = immForm ? rot_imm(issueInstr[STP_ROT_HI:STP_ROT_LO], issueInstr[7:0])
                            : srcRegVal; // RULE20
   assign takeIt = issueValid && ctrl_r[STP_CTRL_EN_BIT];

   stp_saved_bank u_bank (
      .clock(clock),
      .sys_rst(sys_rst),
      .wrEn(bankWe),
      .wrIdx(bankIdx),
      .wrData(bankWd),
      .rdIdx(bankIdx),
      .rdData(bankRd)
   );

   // ****************************************
   // execution next state
   // ****************************************
   always_comb begin
      csw_nxt = csw_r;
      done_nxt = 1'b0;
      pass_nxt = 1'b0;
      gpr_nxt = '{en: 1'b0, idx: issueInstr[STP_RD_HI:STP_RD_LO], data: aluResult};
      pc_nxt = '{en: 1'b0, data: aluResult};
      pcop_nxt = pcop_r;
      cyc_nxt = cyc_r;
      bankWe = 1'b0;
      bankWd = sswCur;
      if (takeIt) begin
         done_nxt = 1'b1;
         pass_nxt = cond_eval(issueInstr[STP_COND_HI:STP_COND_LO],
                              csw_r[STP_FLAG_HI:STP_FLAG_LO]); // RULE9
         cyc_nxt = '{s: STP_CYC_ONE, n: STP_CYC_ZERO, i: STP_CYC_ZERO};
         if (isDp) begin
            pcop_nxt = issueAddr + (regShift ? STP_PC_AHEAD_REG
                                             : STP_PC_AHEAD_IMM); // RULE3 RULE4
         end
         if (pass_nxt && (isRead || isWrite)) begin
            if (isRead) begin
               gpr_nxt.en = 1'b1; // RULE10
               gpr_nxt.data = toSaved ? sswCur : csw_r;
            end else if (!toSaved) begin
               if (flagOnly || userMode) begin
                  csw_nxt[STP_FLAG_HI:STP_FLAG_LO] = xferSrc[STP_FLAG_HI:STP_FLAG_LO]; // RULE12 RULE13
               end else begin
                  csw_nxt = xferSrc & STP_DEFINED_MASK; // RULE11 RULE13 RULE18
               end
            end else if (hasBank) begin
               bankWe = 1'b1; // RULE11 RULE15
               if (flagOnly) begin
                  bankWd = (sswCur & ~STP_FLAG_MASK) | (xferSrc & STP_FLAG_MASK); // RULE12
               end else begin
                  bankWd = xferSrc & STP_DEFINED_MASK;
               end
            end
         end else if (pass_nxt && isDp) begin
            if (testOp) begin
               // no destination write for the flag-only operations
               if (rdIsPc && (opc == STP_OPC_TEQ)) begin
                  if (!userMode && hasBank) begin
                     csw_nxt = restoreVal; // RULE6
                  end
               end else begin
                  csw_nxt[STP_FLAG_HI:STP_FLAG_LO] = aluFlags; // RULE5
               end
            end else if (rdIsPc) begin
               pc_nxt.en = 1'b1; // RULE1
               if (sBit && hasBank) begin
                  csw_nxt = restoreVal; // RULE1
               end
            end else begin
               gpr_nxt.en = 1'b1;
               if (sBit) begin
                  csw_nxt[STP_FLAG_HI:STP_FLAG_LO] = aluFlags;
               end
            end
            cyc_nxt.i = regShift ? STP_CYC_ONE : STP_CYC_ZERO; // RULE7
            if (rdIsPc && !testOp) begin
               cyc_nxt.s = STP_CYC_TWO; // RULE7
               cyc_nxt.n = STP_CYC_ONE;
            end
         end
      end
   end

   // ****************************************
   // register port next state
   // ****************************************
   always_comb begin
      ctrl_nxt = ctrl_r;
      rdata_nxt = 32'h00000000;
      if (regWrite && (regAddr == STP_REG_CTRL)) begin
         ctrl_nxt = regWdata & STP_CTRL_MASK;
      end
      if (regRead) begin
         case (regAddr)
            STP_REG_CTRL: rdata_nxt = ctrl_r;
            STP_REG_CSW: rdata_nxt = csw_r;
            STP_REG_SSW: rdata_nxt = sswCur;
            STP_REG_CYC: rdata_nxt = {26'h0, cyc_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_r <= STP_CTRL_RESET;
         csw_r <= STP_CSW_RESET;
         done_r <= 1'b0;
         pass_r <= 1'b0;
         gpr_r <= '0;
         pc_r <= '0;
         pcop_r <= 32'h00000000;
         cyc_r <= '0;
         rdata_r <= 32'h00000000;
      end else begin
         ctrl_r <= ctrl_nxt;
         csw_r <= csw_nxt;
         done_r <= done_nxt;
         pass_r <= pass_nxt;
         gpr_r <= gpr_nxt;
         pc_r <= pc_nxt;
         pcop_r <= pcop_nxt;
         cyc_r <= cyc_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign done = done_r;
   assign condPassed = pass_r;
   assign gprWrite = gpr_r;
   assign pcWrite = pc_r;
   assign pcOperand = pcop_r;
   assign cycles = cyc_r;
   assign currentStatus = csw_r;
   assign regRdata = rdata_r;

endmodule : stp_exec

/* File: verilog/stp_pkg.sv */
// shared constants, encodings and carrier types for the status transfer unit
package stp_pkg;

   // ****************************************
   // status word layout
   // ****************************************
   localparam int STP_FLAG_HI = 31;
   localparam int STP_FLAG_LO = 28;
   localparam int STP_MODE_HI = 4;
   localparam int STP_MODE_LO = 0;
   localparam logic [31:0] STP_DEFINED_MASK = 32'hf00000ff;
   localparam logic [31:0] STP_FLAG_MASK = 32'hf0000000;
   localparam logic [31:0] STP_CSW_RESET = 32'h000000d3;
   localparam logic [31:0] STP_SSW_RESET = 32'h00000000;

   // ****************************************
   // processor modes and saved status banks
   // ****************************************
   localparam logic [4:0] STP_MODE_USR = 5'h10;
   localparam logic [4:0] STP_MODE_FIQ = 5'h11;
   localparam logic [4:0] STP_MODE_IRQ = 5'h12;
   localparam logic [4:0] STP_MODE_SVC = 5'h13;
   localparam logic [4:0] STP_MODE_ABT = 5'h17;
   localparam logic [4:0] STP_MODE_UND = 5'h1b;
   localparam logic [4:0] STP_MODE_SYS = 5'h1f;
   localparam int STP_BANKS = 5;
   localparam logic [2:0] STP_BANK_FIQ = 3'h0;
   localparam logic [2:0] STP_BANK_IRQ = 3'h1;
   localparam logic [2:0] STP_BANK_SVC = 3'h2;
   localparam logic [2:0] STP_BANK_ABT = 3'h3;
   localparam logic [2:0] STP_BANK_UND = 3'h4;

   // ****************************************
   // instruction fields
   // ****************************************
   localparam int STP_COND_HI = 31;
   localparam int STP_COND_LO = 28;
   localparam int STP_CLASS_HI = 27;
   localparam int STP_CLASS_LO = 26;
   localparam int STP_IMM_BIT = 25;
   localparam int STP_OPC_HI = 24;
   localparam int STP_OPC_LO = 21;
   localparam int STP_SEL_BIT = 22;
   localparam int STP_S_BIT = 20;
   localparam int STP_RD_HI = 15;
   localparam int STP_RD_LO = 12;
   localparam int STP_WHOLE_BIT = 12;
   localparam int STP_ROT_HI = 11;
   localparam int STP_ROT_LO = 8;
   localparam int STP_MUL_BIT = 7;
   localparam int STP_RSHIFT_BIT = 4;
   localparam logic [1:0] STP_CLASS_DP = 2'h0;
   localparam logic [4:0] STP_XFER_TOP = 5'h02;
   localparam logic [1:0] STP_XFER_MID = 2'h2;
   localparam logic [5:0] STP_READ_FIXED = 6'h0f;
   localparam logic [8:0] STP_WRITE_FIXED = 9'h14f;
   localparam logic [11:0] STP_READ_LOW = 12'h000;
   localparam logic [3:0] STP_OPC_TST = 4'h8;
   localparam logic [3:0] STP_OPC_TEQ = 4'h9;
   localparam logic [3:0] STP_OPC_CMP = 4'ha;
   localparam logic [3:0] STP_OPC_CMN = 4'hb;
   localparam logic [3:0] STP_PC_IDX = 4'hf;
   localparam logic [31:0] STP_PC_AHEAD_IMM = 32'h00000008;
   localparam logic [31:0] STP_PC_AHEAD_REG = 32'h0000000c;

   // ****************************************
   // condition codes
   // ****************************************
   typedef enum logic [3:0] {
      STP_EQ = 4'h0, STP_NE = 4'h1, STP_CS = 4'h2, STP_CC = 4'h3,
      STP_MI = 4'h4, STP_PL = 4'h5, STP_VS = 4'h6, STP_VC = 4'h7,
      STP_HI = 4'h8, STP_LS = 4'h9, STP_GE = 4'ha, STP_LT = 4'hb,
      STP_GT = 4'hc, STP_LE = 4'hd, STP_AL = 4'he, STP_NV = 4'hf
   } stp_cond_t;

   // ****************************************
   // incremental cycle figures
   // ****************************************
   localparam logic [1:0] STP_CYC_ZERO = 2'h0;
   localparam logic [1:0] STP_CYC_ONE = 2'h1;
   localparam logic [1:0] STP_CYC_TWO = 2'h2;

   // ****************************************
   // register port map
   // ****************************************
   localparam logic [3:0] STP_REG_CTRL = 4'h0;
   localparam logic [3:0] STP_REG_CSW = 4'h4;
   localparam logic [3:0] STP_REG_SSW = 4'h8;
   localparam logic [3:0] STP_REG_CYC = 4'hc;
   localparam int STP_CTRL_EN_BIT = 0;
   localparam logic [31:0] STP_CTRL_RESET = 32'h00000001;
   localparam logic [31:0] STP_CTRL_MASK = 32'h00000001;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic en;
      logic [3:0] idx;
      logic [31:0] data;
   } stp_gpr_wr_t;

   typedef struct packed {
      logic en;
      logic [31:0] data;
   } stp_pc_wr_t;

   typedef struct packed {
      logic [1:0] s;
      logic [1:0] n;
      logic [1:0] i;
   } stp_cycles_t;

endpackage : stp_pkg

/* File: verilog/stp_saved_bank.sv */
// banked saved status words, one per privileged exception mode
`timescale 1ns/100ps
module stp_saved_bank
   import stp_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // write port
   input wire logic wrEn,
   input wire logic [2:0] wrIdx,
   input wire logic [31:0] wrData,
   // read port
   input wire logic [2:0] rdIdx,
   output logic [31:0] rdData
);

   logic [31:0] bank_r [STP_BANKS];
   logic [31:0] bank_nxt [STP_BANKS];

   always_comb begin
      for (int k = 0; k < STP_BANKS; k++) begin
         bank_nxt[k] = bank_r[k];
      end
      if (wrEn && (int'(wrIdx) < STP_BANKS)) begin
         bank_nxt[wrIdx] = wrData;
      end
   end

   always_ff @(posedge clock) begin
      for (int k = 0; k < STP_BANKS; k++) begin
         if (sys_rst) begin
            bank_r[k] <= STP_SSW_RESET;
         end else begin
            bank_r[k] <= bank_nxt[k];
         end
      end
   end

   // combinational read so a restore sees the bank in the issue cycle
   assign rdData = (int'(rdIdx) < STP_BANKS) ? bank_r[rdIdx] : STP_SSW_RESET;

endmodule : stp_saved_bank
